//--- pdc_pkg.sv
// constants shared by the device capability and control register block
package pdc_pkg;

  // ************************************************************
  // configuration-space map
  // ************************************************************
  localparam int          PDC_ADDR_W    = 12;
  localparam logic [11:0] PDC_CAP_OFF   = 12'h0A4;
  localparam logic [11:0] PDC_CTL_OFF   = 12'h0A8;

  // ************************************************************
  // capability word field positions
  // ************************************************************
  localparam int PDC_CAP_MPS_LSB  = 0;
  localparam int PDC_CAP_L0S_LSB  = 6;
  localparam int PDC_CAP_L1_LSB   = 9;
  localparam int PDC_CAP_RBER_BIT = 15;
  localparam int PDC_CAP_FLR_BIT  = 28;

  // capability values after reset, replaced by nonvolatile loads except the fixed error reporting bit
  localparam logic [2:0] PDC_MPS_SUP_RST = 3'h2;
  localparam logic [2:0] PDC_L0S_LAT_RST = 3'h3;
  localparam logic [2:0] PDC_L1_LAT_RST  = 3'h6;
  localparam logic       PDC_FLR_CAP_RST = 1'h1;
  localparam logic       PDC_RBER_VAL    = 1'h1;

  // ************************************************************
  // control word field positions
  // ************************************************************
  localparam int PDC_CTL_ERR_LSB  = 0;
  localparam int PDC_CTL_RO_BIT   = 4;
  localparam int PDC_CTL_MPS_LSB  = 5;
  localparam int PDC_CTL_AUX_BIT  = 10;
  localparam int PDC_CTL_NS_BIT   = 11;
  localparam int PDC_CTL_MRRS_LSB = 12;
  localparam int PDC_CTL_FLR_BIT  = 15;

  // control values after reset
  localparam logic [3:0] PDC_ERR_EN_RST = 4'h0;
  localparam logic       PDC_RO_EN_RST  = 1'h1;
  localparam logic [2:0] PDC_MPS_RST    = 3'h0;
  localparam logic       PDC_AUX_RST    = 1'h0;
  localparam logic       PDC_NS_EN_RST  = 1'h1;
  localparam logic [2:0] PDC_MRRS_RST   = 3'h2;

  // size decode: code n means 128 << n bytes
  localparam logic [2:0]  PDC_MRRS_MAX_CODE = 3'h3;
  localparam logic [12:0] PDC_SIZE_BASE     = 13'h0080;

endpackage

//--- pdc_nvm_latch.sv
// holder for the capability fields preset from nonvolatile configuration
`timescale 1ns/1ps

module pdc_nvm_latch
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // values from the nonvolatile loader
  input  wire logic       nvm_load,
  input  wire logic [2:0] nvm_mps_sup,
  input  wire logic [2:0] nvm_l0s_lat,
  input  wire logic [2:0] nvm_l1_lat,
  input  wire logic       nvm_flr_cap,
  // held capability fields
  output logic      [2:0] mps_sup,
  output logic      [2:0] l0s_lat,
  output logic      [2:0] l1_lat,
  output logic            flr_cap
);

  import pdc_pkg::*;

  typedef struct packed {
    logic [2:0] mps_sup;
    logic [2:0] l0s_lat;
    logic [2:0] l1_lat;
    logic       flr_cap;
  } pdc_nvm_t;

  pdc_nvm_t st_r;
  pdc_nvm_t st_nxt;

  // take a new set only on the loader strobe; defaults hold until then
  always_comb
  begin
    st_nxt = st_r;
    if (nvm_load)
    begin
      st_nxt.mps_sup = nvm_mps_sup;
      st_nxt.l0s_lat = nvm_l0s_lat;
      st_nxt.l1_lat  = nvm_l1_lat;
      st_nxt.flr_cap = nvm_flr_cap;
    end
  end

  // reset brings back the documented defaults
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r.mps_sup <= PDC_MPS_SUP_RST;
      st_r.l0s_lat <= PDC_L0S_LAT_RST;
      st_r.l1_lat  <= PDC_L1_LAT_RST;
      st_r.flr_cap <= PDC_FLR_CAP_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign mps_sup = st_r.mps_sup;
  assign l0s_lat = st_r.l0s_lat;
  assign l1_lat  = st_r.l1_lat;
  assign flr_cap = st_r.flr_cap;

endmodule

//--- pdc_device_cap_control.sv
// device capability and device control words of the express capability structure
`timescale 1ns/1ps

module pdc_device_cap_control
#(
  parameter int SNOOP_GATE_W = 1
)
(
  // clock and power-up or link reset
  input  wire logic                           ref_clk,
  input  wire logic                           rst_n,
  // configuration access port
  input  wire logic                           cfg_rd,
  input  wire logic                           cfg_wr,
  input  wire logic [pdc_pkg::PDC_ADDR_W-1:0] cfg_addr,
  input  wire logic [3:0]                     cfg_be,
  input  wire logic [31:0]                    cfg_wdata,
  output logic      [31:0]                    cfg_rdata,
  output logic                                cfg_rd_valid,
  // nonvolatile presets for the capability word
  input  wire logic                           nvm_load,
  input  wire logic [2:0]                     nvm_mps_sup,
  input  wire logic [2:0]                     nvm_l0s_lat,
  input  wire logic [2:0]                     nvm_l1_lat,
  input  wire logic                           nvm_flr_cap,
  // gates held in the device's own control registers
  input  wire logic                           relaxed_order_disable,
  input  wire logic [SNOOP_GATE_W-1:0]        snoop_gate_bits,
  // controls steering the transaction layer
  output logic      [3:0]                     err_report_en,
  output logic                                relaxed_ord_en,
  output logic      [SNOOP_GATE_W-1:0]        no_snoop_en,
  output logic      [2:0]                     max_payload_code,
  output logic      [12:0]                    max_payload_bytes,
  output logic      [2:0]                     max_rd_req_code,
  output logic      [12:0]                    max_rd_req_bytes,
  output logic                                aux_pwr_en,
  output logic                                flr_start
);

  import pdc_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [3:0]  err_en;
    logic        ro_en;
    logic [2:0]  mps;
    logic        aux_pm;
    logic        ns_en;
    logic [2:0]  mrrs;
    logic        flr_pend;
    logic [31:0] rdata;
    logic        rvalid;
    logic [12:0] pay_bytes;
    logic [12:0] rrq_bytes;
  } pdc_ctl_t;

  pdc_ctl_t    st_r;
  pdc_ctl_t    st_nxt;

  logic [2:0]  mps_sup;
  logic [2:0]  l0s_lat;
  logic [2:0]  l1_lat;
  logic        flr_cap;
  logic [31:0] cap_word;
  logic [15:0] ctl_word;
  logic        hit_cap;
  logic        hit_ctl;

  // ************************************************************
  // nonvolatile capability presets
  // ************************************************************
  pdc_nvm_latch u_nvm
  (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .nvm_load    (nvm_load),
    .nvm_mps_sup (nvm_mps_sup),
    .nvm_l0s_lat (nvm_l0s_lat),
    .nvm_l1_lat  (nvm_l1_lat),
    .nvm_flr_cap (nvm_flr_cap),
    .mps_sup     (mps_sup),
    .l0s_lat     (l0s_lat),
    .l1_lat      (l1_lat),
    .flr_cap     (flr_cap)
  );

  // ************************************************************
  // read images of the two words
  // ************************************************************
  // dword decode; byte lanes only matter on writes
  assign hit_cap = (cfg_addr[PDC_ADDR_W-1:2] == PDC_CAP_OFF[PDC_ADDR_W-1:2]);
  assign hit_ctl = (cfg_addr[PDC_ADDR_W-1:2] == PDC_CTL_OFF[PDC_ADDR_W-1:2]);

  // capability image: hardwired zeros everywhere except the named fields
  always_comb
  begin
    cap_word                                      = 32'h0000_0000;
    cap_word[PDC_CAP_MPS_LSB +: 3]                = mps_sup;
    cap_word[PDC_CAP_L0S_LSB +: 3]                = l0s_lat;
    cap_word[PDC_CAP_L1_LSB +: 3]                 = l1_lat;
    cap_word[PDC_CAP_RBER_BIT]                    = PDC_RBER_VAL;
    cap_word[PDC_CAP_FLR_BIT]                     = flr_cap;
  end

  // control image: bits 9:8 and 15 always read zero
  always_comb
  begin
    ctl_word                                = 16'h0000;
    ctl_word[PDC_CTL_ERR_LSB +: 4]          = st_r.err_en;
    ctl_word[PDC_CTL_RO_BIT]                = st_r.ro_en;
    ctl_word[PDC_CTL_MPS_LSB +: 3]          = st_r.mps;
    ctl_word[PDC_CTL_AUX_BIT]               = st_r.aux_pm;
    ctl_word[PDC_CTL_NS_BIT]                = st_r.ns_en;
    ctl_word[PDC_CTL_MRRS_LSB +: 3]         = st_r.mrrs;
  end

  // ************************************************************
  // next state
  // ************************************************************
  // a pending function reset outranks a write in the same cycle, so the
  // host sees a clean default set afterwards; one write may be lost there
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.flr_pend = 1'b0;
    st_nxt.rvalid   = cfg_rd;
    if (cfg_rd)
    begin
      // unmapped and status halves read zero
      st_nxt.rdata = 32'h0000_0000;
      if (hit_cap)
      begin
        st_nxt.rdata = cap_word;
      end
      else if (hit_ctl)
      begin
        st_nxt.rdata = {16'h0000, ctl_word};
      end
    end
    if (st_r.flr_pend)
    begin
      // payload limit and sticky aux enable survive the function reset
      st_nxt.err_en = PDC_ERR_EN_RST;
      st_nxt.ro_en  = PDC_RO_EN_RST;
      st_nxt.ns_en  = PDC_NS_EN_RST;
      st_nxt.mrrs   = PDC_MRRS_RST;
    end
    else if (cfg_wr && hit_ctl)
    begin
      // capability word has no write path at all
      if (cfg_be[0])
      begin
        st_nxt.err_en = cfg_wdata[PDC_CTL_ERR_LSB +: 4];
        st_nxt.ro_en  = cfg_wdata[PDC_CTL_RO_BIT];
        st_nxt.mps    = cfg_wdata[PDC_CTL_MPS_LSB +: 3];
      end
      if (cfg_be[1])
      begin
        st_nxt.aux_pm   = cfg_wdata[PDC_CTL_AUX_BIT];
        st_nxt.ns_en    = cfg_wdata[PDC_CTL_NS_BIT];
        st_nxt.flr_pend = cfg_wdata[PDC_CTL_FLR_BIT];
        // reserved request sizes are dropped, the old limit stays
        if (cfg_wdata[PDC_CTL_MRRS_LSB +: 3] <= PDC_MRRS_MAX_CODE)
        begin
          st_nxt.mrrs = cfg_wdata[PDC_CTL_MRRS_LSB +: 3];
        end
      end
    end
    // size decodes registered so the byte outputs come straight off flops
    st_nxt.pay_bytes = PDC_SIZE_BASE << st_nxt.mps;
    st_nxt.rrq_bytes = PDC_SIZE_BASE << st_nxt.mrrs;
  end

  // ************************************************************
  // registers
  // ************************************************************
  // power-up and link reset both arrive on rst_n
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r.err_en   <= PDC_ERR_EN_RST;
      st_r.ro_en    <= PDC_RO_EN_RST;
      st_r.mps      <= PDC_MPS_RST;
      st_r.aux_pm   <= PDC_AUX_RST;
      st_r.ns_en    <= PDC_NS_EN_RST;
      st_r.mrrs     <= PDC_MRRS_RST;
      st_r.flr_pend <= 1'b0;
      st_r.rdata    <= 32'h0000_0000;
      st_r.rvalid   <= 1'b0;
      st_r.pay_bytes <= PDC_SIZE_BASE << PDC_MPS_RST;
      st_r.rrq_bytes <= PDC_SIZE_BASE << PDC_MRRS_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // attribute gates combine the host enable with the device's relaxed-order disable and no-snoop gate bits
  assign cfg_rdata         = st_r.rdata;
  assign cfg_rd_valid      = st_r.rvalid;
  assign err_report_en     = st_r.err_en;
  assign relaxed_ord_en    = st_r.ro_en & ~relaxed_order_disable;
  assign no_snoop_en       = {SNOOP_GATE_W{st_r.ns_en}} & snoop_gate_bits;
  assign max_payload_code  = st_r.mps;
  assign max_payload_bytes = st_r.pay_bytes;
  assign max_rd_req_code   = st_r.mrrs;
  assign max_rd_req_bytes  = st_r.rrq_bytes;
  assign aux_pwr_en        = st_r.aux_pm;
  assign flr_start         = st_r.flr_pend;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_cap_mps_read: assert property (
    (cfg_rd && hit_cap) |=> (cfg_rd_valid && cfg_rdata[2:0] == $past(mps_sup)))
    else $error("supported payload field wrong on read");

  a_cap_fixed_zero: assert property (
    (cfg_rd && hit_cap) |=> (cfg_rdata[5:3] == 3'h0 && cfg_rdata[14:12] == 3'h0 && cfg_rdata[27:16] == 12'h000))
    else $error("hardwired capability bits not zero");

  a_cap_latency: assert property (
    (cfg_rd && hit_cap) |=> (cfg_rdata[8:6] == $past(l0s_lat) && cfg_rdata[11:9] == $past(l1_lat)))
    else $error("latency fields wrong on read");

  a_cap_rber_flr: assert property (
    (cfg_rd && hit_cap) |=> (cfg_rdata[15] && cfg_rdata[28] == $past(flr_cap) && cfg_rdata[31:29] == 3'h0))
    else $error("error reporting or reset capability bit wrong");

  a_ctl_zero_bits: assert property (
    (cfg_rd && hit_ctl) |=> (cfg_rdata[15] == 1'b0 && cfg_rdata[9:8] == 2'h0 && cfg_rdata[31:16] == 16'h0000))
    else $error("control read shows reserved or reset bits");

  a_err_en_write: assert property (
    (cfg_wr && hit_ctl && cfg_be[0] && !flr_start)
      |=> (err_report_en == $past(cfg_wdata[3:0]) && max_payload_code == $past(cfg_wdata[7:5])))
    else $error("control low byte not taken");

  a_ro_gate: assert property (
    (cfg_wr && hit_ctl && cfg_be[0] && !flr_start && !cfg_wdata[4]) |=> !relaxed_ord_en)
    else $error("relaxed ordering allowed after host cleared it");

  a_flr_pulse: assert property (
    (cfg_wr && hit_ctl && cfg_be[1] && cfg_wdata[15] && !flr_start) |=> flr_start ##1 !flr_start)
    else $error("function reset start not a single pulse");

  a_flr_keeps_mps: assert property (
    flr_start |=> ($stable(max_payload_code) && $stable(aux_pwr_en) && max_rd_req_code == PDC_MRRS_RST))
    else $error("function reset disturbed payload limit or sticky bit");

  a_mrrs_legal: assert property (
    (cfg_wr && hit_ctl && cfg_be[1] && !flr_start && cfg_wdata[14:12] > 3'h3) |=> $stable(max_rd_req_code))
    else $error("reserved read request size accepted");

  a_cap_no_write: assert property (
    (cfg_wr && hit_cap && !flr_start) |=> ($stable(err_report_en) && $stable(max_rd_req_code) && $stable(aux_pwr_en)))
    else $error("capability write changed control state");

  a_snoop_gate: assert property (
    (cfg_wr && hit_ctl && cfg_be[1] && !flr_start && !cfg_wdata[11]) |=> (no_snoop_en == '0))
    else $error("no-snoop allowed after host cleared it");

  // lane, gate and preset checks; a lane left out of a write must not leak
  a_ro_set: assert property (
    (cfg_wr && hit_ctl && cfg_be[0] && !flr_start && cfg_wdata[4]) |=> (relaxed_ord_en == !relaxed_order_disable))
    else $error("relaxed ordering not granted after host set it");

  a_aux_write: assert property (
    (cfg_wr && hit_ctl && cfg_be[1] && !flr_start) |=> (aux_pwr_en == $past(cfg_wdata[10])))
    else $error("auxiliary power enable not taken");

  a_ns_write: assert property (
    (cfg_wr && hit_ctl && cfg_be[1] && !flr_start && cfg_wdata[11]) |=> (no_snoop_en == snoop_gate_bits))
    else $error("no-snoop not granted where the gate allows it");

  a_mps_hold_be: assert property (
    (cfg_wr && hit_ctl && !cfg_be[0]) |=> $stable(max_payload_code))
    else $error("payload limit changed without its byte lane");

  a_err_hold_be: assert property (
    (cfg_wr && hit_ctl && !cfg_be[0] && !flr_start) |=> $stable(err_report_en))
    else $error("error enables changed without their byte lane");

  a_ctl_high_lanes: assert property (
    (cfg_wr && hit_ctl && cfg_be[1:0] == 2'h0 && !flr_start)
      |=> ($stable(err_report_en) && $stable(aux_pwr_en) && $stable(max_rd_req_code) && !flr_start))
    else $error("write to the status half changed control state");

  a_mrrs_range: assert property (
    max_rd_req_code <= PDC_MRRS_MAX_CODE)
    else $error("read request limit holds a reserved code");

  a_flr_defaults: assert property (
    flr_start |=> (!flr_start && err_report_en == PDC_ERR_EN_RST && relaxed_ord_en == !relaxed_order_disable
                   && no_snoop_en == snoop_gate_bits))
    else $error("function reset left control defaults unrestored");

  a_unmapped_zero: assert property (
    (cfg_rd && !hit_cap && !hit_ctl) |=> (cfg_rd_valid && cfg_rdata == 32'h0000_0000))
    else $error("unmapped read did not return zero");

  a_ctl_read_image: assert property (
    (cfg_rd && hit_ctl) |=> (cfg_rd_valid && cfg_rdata[3:0] == $past(err_report_en)
                             && cfg_rdata[7:5] == $past(max_payload_code) && cfg_rdata[10] == $past(aux_pwr_en)
                             && cfg_rdata[14:12] == $past(max_rd_req_code)))
    else $error("control read image disagrees with the control outputs");

  a_nvm_preset: assert property (
    nvm_load |=> (mps_sup == $past(nvm_mps_sup) && l0s_lat == $past(nvm_l0s_lat)
                  && l1_lat == $past(nvm_l1_lat) && flr_cap == $past(nvm_flr_cap)))
    else $error("nonvolatile presets not taken on the load strobe");

endmodule

//--- pdc_host_model.sv
// host model issuing configuration reads and writes
`timescale 1ns/1ps

module pdc_host_model
(
  // clock
  input  wire logic                          ref_clk,
  // configuration requests
  output logic                               cfg_rd,
  output logic                               cfg_wr,
  output logic      [pdc_pkg::PDC_ADDR_W-1:0] cfg_addr,
  output logic      [3:0]                    cfg_be,
  output logic      [31:0]                   cfg_wdata,
  // answers
  input  wire logic [31:0]                   cfg_rdata,
  input  wire logic                          cfg_rd_valid
);
  import pdc_pkg::*;

  // quiet bus at time zero
  initial
  begin
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = 12'h000;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // idle cycle; released data toggles so a stale value never looks valid
  task automatic idle();
    @(posedge ref_clk);
    cfg_rd    <= 1'b0;
    cfg_wr    <= 1'b0;
    cfg_wdata <= ~cfg_wdata;
  endtask

  // one write, taken at the next edge; callers keep payload codes legal
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge ref_clk);
    cfg_rd    <= 1'b0;
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
  endtask

  // one read; the answer must be there half a cycle after the taking edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output bit ok);
    @(posedge ref_clk);
    cfg_wr   <= 1'b0;
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    idle();
    @(negedge ref_clk);
    ok = (cfg_rd_valid === 1'b1);
    d  = cfg_rdata;
  endtask
endmodule

//--- pcie_device_cap_control_bench.sv
// self-checking bench for the device capability and control words
`timescale 1ns/1ps

module pcie_device_cap_control_bench;
  import pdc_pkg::*;

  // ****************
  // signals
  // ****************
  logic                  ref_clk;
  logic                  rst_n;
  logic                  cfg_rd;
  logic                  cfg_wr;
  logic [PDC_ADDR_W-1:0] cfg_addr;
  logic [3:0]            cfg_be;
  logic [31:0]           cfg_wdata;
  logic [31:0]           cfg_rdata;
  logic                  cfg_rd_valid;
  logic                  nvm_load;
  logic [2:0]            nvm_mps_sup;
  logic [2:0]            nvm_l0s_lat;
  logic [2:0]            nvm_l1_lat;
  logic                  nvm_flr_cap;
  logic                  relaxed_order_disable;
  logic [0:0]            snoop_gate_bits;
  logic [3:0]            err_report_en;
  logic                  relaxed_ord_en;
  logic [0:0]            no_snoop_en;
  logic [2:0]            max_payload_code;
  logic [12:0]           max_payload_bytes;
  logic [2:0]            max_rd_req_code;
  logic [12:0]           max_rd_req_bytes;
  logic                  aux_pwr_en;
  logic                  flr_start;
  logic [31:0]           ctl_outs;
  logic [2:0]            mrrs_exp;
  int                    mismatches;
  int                    num_checks;

  // control outputs packed for one compare
  assign ctl_outs = {18'h0, err_report_en, relaxed_ord_en, no_snoop_en, aux_pwr_en, flr_start,
                     max_payload_code, max_rd_req_code};

  // 125 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ****************
  // design and host
  // ****************
  pdc_device_cap_control #(.SNOOP_GATE_W(1)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
    .nvm_load(nvm_load), .nvm_mps_sup(nvm_mps_sup), .nvm_l0s_lat(nvm_l0s_lat),
    .nvm_l1_lat(nvm_l1_lat), .nvm_flr_cap(nvm_flr_cap),
    .relaxed_order_disable(relaxed_order_disable), .snoop_gate_bits(snoop_gate_bits),
    .err_report_en(err_report_en), .relaxed_ord_en(relaxed_ord_en), .no_snoop_en(no_snoop_en),
    .max_payload_code(max_payload_code), .max_payload_bytes(max_payload_bytes),
    .max_rd_req_code(max_rd_req_code), .max_rd_req_bytes(max_rd_req_bytes),
    .aux_pwr_en(aux_pwr_en), .flr_start(flr_start));

  pdc_host_model i_host (
    .ref_clk(ref_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid));

  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read and compare; a missing answer counts too
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bit          ok;
    i_host.rd(a, d, ok);
    chk({31'h0, ok}, 32'h1);
    chk(d, exp);
  endtask

  // write, let it land, then look at settled outputs
  task automatic put(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    i_host.wr(a, be, d);
    i_host.idle();
    @(negedge ref_clk);
  endtask

  task automatic done(input string name);
    $display("test %s ended: %0d checks, %0d mismatches", name, num_checks, mismatches);
  endtask

  task automatic defaults();
    rdc(PDC_CAP_OFF, 32'h1000_8CC2);
    rdc(PDC_CTL_OFF, 32'h0000_2810);
    chk(ctl_outs, 32'h0000_0302);
    chk(32'(max_payload_bytes), 32'h80);
    chk(32'(max_rd_req_bytes), 32'h200);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end

  // ****************
  // tests
  // ****************
  initial
  begin
    rst_n                 = 1'b0;
    nvm_load              = 1'b0;
    nvm_mps_sup           = 3'h1;
    nvm_l0s_lat           = 3'h5;
    nvm_l1_lat            = 3'h2;
    nvm_flr_cap           = 1'b0;
    relaxed_order_disable = 1'b0;
    snoop_gate_bits       = 1'b1;
    mismatches            = 0;
    num_checks            = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    defaults();
    done("reset values");
    // read-only word and an unmapped place
    put(PDC_CAP_OFF, 4'hF, 32'hFFFF_FFFF);
    rdc(PDC_CAP_OFF, 32'h1000_8CC2);
    put(12'h0B4, 4'hF, 32'hFFFF_FFFF);
    rdc(12'h0B4, 32'h0);
    put(PDC_CTL_OFF, 4'hC, 32'hFFFF_FFFF);
    rdc(PDC_CTL_OFF, 32'h0000_2810);
    done("read-only");
    // every enable bit set, function reset left clear, payload code kept within the supported one
    put(PDC_CTL_OFF, 4'hF, 32'hFFFF_3F5F);
    rdc(PDC_CTL_OFF, 32'h0000_3C5F);
    chk(ctl_outs, 32'h0000_3F93);
    chk(32'(max_payload_bytes), 32'h200);
    done("control write");
    // every read request code; reserved codes keep the old value
    mrrs_exp = 3'h3;
    for (int c = 0; c < 8; c++)
    begin
      put(PDC_CTL_OFF, 4'h2, 32'h0C00 | (32'(c) << 12));
      if (c < 4)
        mrrs_exp = 3'(c);
      chk(32'(max_rd_req_code), 32'(mrrs_exp));
      chk(32'(max_rd_req_bytes), 32'h80 << mrrs_exp);
    end
    done("read request codes");
    // gates held elsewhere in the device, then the control bits cleared
    @(posedge ref_clk);
    relaxed_order_disable <= 1'b1;
    snoop_gate_bits       <= 1'b0;
    @(negedge ref_clk);
    chk({30'h0, relaxed_ord_en, no_snoop_en}, 32'h0);
    @(posedge ref_clk);
    relaxed_order_disable <= 1'b0;
    snoop_gate_bits       <= 1'b1;
    put(PDC_CTL_OFF, 4'h1, 32'h0000_004F);
    put(PDC_CTL_OFF, 4'h2, 32'h0000_3400);
    rdc(PDC_CTL_OFF, 32'h0000_344F);
    chk({30'h0, relaxed_ord_en, no_snoop_en}, 32'h0);
    done("gates");
    // function reset with a write right behind it, which must be dropped
    i_host.wr(PDC_CTL_OFF, 4'h2, 32'h0000_BC00);
    i_host.wr(PDC_CTL_OFF, 4'h1, 32'h0000_001F);
    @(negedge ref_clk);
    chk({31'h0, flr_start}, 32'h1);
    i_host.idle();
    @(negedge ref_clk);
    chk({31'h0, flr_start}, 32'h0);
    rdc(PDC_CTL_OFF, 32'h0000_2C50);
    chk(ctl_outs, 32'h0000_0392);
    done("function reset");
    // nonvolatile presets replace the capability defaults
    @(posedge ref_clk);
    nvm_load <= 1'b1;
    @(posedge ref_clk);
    nvm_load <= 1'b0;
    rdc(PDC_CAP_OFF, 32'h0000_8541);
    done("presets");
    // link reset in mid-run restores every reset default, sticky bit and capability presets included
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    defaults();
    done("second reset");
    conclude();
  end
endmodule
